// *** bgt_threshold_regs.sv ***
/*
 command-bus register bank for white ratio and gray threshold floors, and
 the clamp that applies the floor of the current content mode.
 assumes an outside histogram stage supplies the computed threshold.
*/
// Notes on behaviour
// RULE1: command CAh sets UI white ratio, default 0Bh
// RULE2: UI ratio limits share of pixels at 63
// RULE3: threshold keeps the fixed white pixel count
// RULE4: command CBh sets moving/still floors, default A8h
// RULE5: moving floor 224 down by four to 164
// RULE6: still code sets the still threshold floor
// RULE7: command CCh sets UI floor, default 03h
// RULE8: UI floor 252 down by four to 192
// RULE9: settings accepted in every power state
// RULE10: host sends command then parameter on rising strobe
// RULE11: use setting set of the current mode
`timescale 1ns/1ps
module bgt_threshold_regs (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              data_command_select,
   input  wire logic              read_strobe_n,
   input  wire logic              write_strobe_n,
   input  wire logic [23:0]       data_bus,
   input  wire bgt_pkg::bgt_mode_t content_mode,
   input  wire logic [7:0]        computed_gray_threshold,
   input  wire logic [7:0]        pixel_gray,
   output logic      [7:0]        ui_white_ratio,
   output logic      [7:0]        motion_still_gray_floor,
   output logic      [7:0]        ui_gray_floor,
   output logic      [3:0]        ui_white_ratio_code,
   output logic      [7:0]        white_gray_threshold,
   output logic                   pixel_is_white,
   output logic      [5:0]        pixel_out
);
   logic [bgt_pkg::PIN_W-1:0] pins_lvl;
   logic                      dcx_l, rd_n_l, wr_n_l, wr_n_prev, wr_rise;
   logic [7:0]                byte_l;
   logic [7:0]                cmd, next_cmd;
   logic                      param_pend, next_param_pend;
   logic [7:0]                next_ui_white_ratio, next_ms_floor, next_ui_floor;
   logic [7:0]                floor_sel, next_threshold;
   logic                      next_pixel_is_white;
   logic [5:0]                next_pixel_out;
   logic [3:0]                motion_code, still_code, ui_code;

   // all command pins come from the host's domain
   bgt_pin_sync #(
      .W       (bgt_pkg::PIN_W),
      .RST_VAL (bgt_pkg::PIN_IDLE)
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin_in  ({data_command_select, read_strobe_n, write_strobe_n, data_bus}),
      .level   (pins_lvl)
   );

   // pin fields; data bits above 7 are ignored
   // a strobe is seen only after the filter, so each phase needs two clocks
   assign dcx_l   = pins_lvl[26];
   assign rd_n_l  = pins_lvl[25];
   assign wr_n_l  = pins_lvl[24];
   assign byte_l  = pins_lvl[7:0];                              // [RULE10]
   assign wr_rise = wr_n_l & ~wr_n_prev & rd_n_l;               // [RULE10]

   // command decode and parameter capture; no power state gates it [RULE9]
   always_comb begin
      next_cmd            = cmd;
      next_param_pend     = param_pend;
      next_ui_white_ratio = ui_white_ratio;
      next_ms_floor       = motion_still_gray_floor;
      next_ui_floor       = ui_gray_floor;
      if (wr_rise && !dcx_l) begin
         next_cmd        = byte_l;                              // [RULE10]
         next_param_pend = 1'b1;
      end else if (wr_rise && dcx_l && param_pend) begin
         next_param_pend = 1'b0;                                // one byte each
         if (cmd == bgt_pkg::CMD_UI_WHITE_RATIO) begin
            next_ui_white_ratio = {4'h0, byte_l[3:0]};          // [RULE1]
         end else if (cmd == bgt_pkg::CMD_MOTION_STILL_FLOOR) begin
            next_ms_floor = byte_l;                             // [RULE4]
         end else if (cmd == bgt_pkg::CMD_UI_GRAY_FLOOR) begin
            next_ui_floor = {4'h0, byte_l[3:0]};                // [RULE7]
         end
      end
   end

   // command state and the three settings
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd                     <= bgt_pkg::RST_CMD;
         param_pend              <= 1'b0;
         wr_n_prev               <= 1'b1;
         ui_white_ratio          <= bgt_pkg::RST_UI_WHITE_RATIO;
         motion_still_gray_floor <= bgt_pkg::RST_MOTION_STILL_FLOOR;
         ui_gray_floor           <= bgt_pkg::RST_UI_GRAY_FLOOR;
      end else begin
         cmd                     <= next_cmd;
         param_pend              <= next_param_pend;
         wr_n_prev               <= wr_n_l;
         ui_white_ratio          <= next_ui_white_ratio;
         motion_still_gray_floor <= next_ms_floor;
         ui_gray_floor           <= next_ui_floor;
      end
   end

   // code fields
   assign motion_code         = motion_still_gray_floor[bgt_pkg::MOTION_CODE_LSB +: 4];
   assign still_code          = motion_still_gray_floor[bgt_pkg::STILL_CODE_LSB +: 4];
   assign ui_code             = ui_gray_floor[3:0];
   assign ui_white_ratio_code = ui_white_ratio[3:0];            // [RULE2]

   // floor of the current mode, clamp, and white mapping
   always_comb begin
      case (content_mode)
         bgt_pkg::BGT_MODE_MOVING:
            floor_sel = 8'(bgt_pkg::MOTION_FLOOR_BASE - bgt_pkg::FLOOR_STEP * motion_code); // [RULE5]
         bgt_pkg::BGT_MODE_STILL:
            floor_sel = 8'(bgt_pkg::MOTION_FLOOR_BASE - bgt_pkg::FLOOR_STEP * still_code);  // [RULE6]
         default:
            floor_sel = 8'(bgt_pkg::UI_FLOOR_BASE - bgt_pkg::FLOOR_STEP * ui_code);         // [RULE8]
      endcase
      // the incoming threshold already keeps the white count; only raise it
      next_threshold = (computed_gray_threshold < floor_sel) ?
                       floor_sel : computed_gray_threshold;     // [RULE3] [RULE11]
      next_pixel_is_white = (pixel_gray >= white_gray_threshold);
      next_pixel_out = next_pixel_is_white ? bgt_pkg::WHITE_LEVEL : pixel_gray[7:2]; // [RULE2]
   end

   // registered threshold and pixel outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         white_gray_threshold <= bgt_pkg::RST_THRESHOLD;
         pixel_is_white       <= 1'b0;
         pixel_out            <= bgt_pkg::RST_PIXEL_OUT;
      end else begin
         white_gray_threshold <= next_threshold;
         pixel_is_white       <= next_pixel_is_white;
         pixel_out            <= next_pixel_out;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_cmd_capture: assert property (wr_rise && !dcx_l |=> cmd == $past(byte_l)) // [RULE10]
      else $error("command byte not captured");
   chk_ui_ratio_write: assert property (wr_rise && dcx_l && param_pend &&
      cmd == bgt_pkg::CMD_UI_WHITE_RATIO |=> ui_white_ratio == {4'h0, $past(byte_l[3:0])}) // [RULE1]
      else $error("ui white ratio not written");
   chk_ms_floor_write: assert property (wr_rise && dcx_l && param_pend &&
      cmd == bgt_pkg::CMD_MOTION_STILL_FLOOR |=> motion_still_gray_floor == $past(byte_l)) // [RULE4]
      else $error("motion still floor not written");
   chk_ui_floor_write: assert property (wr_rise && dcx_l && param_pend &&
      cmd == bgt_pkg::CMD_UI_GRAY_FLOOR |=> ui_gray_floor == {4'h0, $past(byte_l[3:0])}) // [RULE7]
      else $error("ui floor not written");
   chk_moving_floor: assert property (content_mode == bgt_pkg::BGT_MODE_MOVING |=>
      white_gray_threshold >= 8'(8'd224 - 8'd4 * $past(motion_code))) // [RULE5]
      else $error("moving threshold below floor");
   chk_still_floor: assert property (content_mode == bgt_pkg::BGT_MODE_STILL |=>
      white_gray_threshold >= 8'(8'd224 - 8'd4 * $past(still_code))) // [RULE6]
      else $error("still threshold below floor");
   chk_ui_floor_clamp: assert property (content_mode == bgt_pkg::BGT_MODE_UI |=>
      white_gray_threshold >= 8'(8'd252 - 8'd4 * $past(ui_code))) // [RULE8]
      else $error("ui threshold below floor");
   chk_thresh_pass: assert property (computed_gray_threshold >= 8'd252 |=>
      white_gray_threshold == $past(computed_gray_threshold)) // [RULE3]
      else $error("threshold changed above floor");
   chk_white_map: assert property (pixel_is_white |-> pixel_out == 6'd63) // [RULE2]
      else $error("white pixel not at level 63");

   // refused traffic leaves the bank alone
   chk_lone_param: assert property (wr_rise && dcx_l && !param_pend |=> // [RULE10]
      $stable(ui_white_ratio) && $stable(motion_still_gray_floor) && $stable(ui_gray_floor))
      else $error("parameter without command changed a register");
   chk_read_refused: assert property (!rd_n_l |=> // [RULE10]
      $stable(cmd) && $stable(param_pend) && $stable(ui_white_ratio) &&
      $stable(motion_still_gray_floor) && $stable(ui_gray_floor))
      else $error("write taken while read strobe low");
   chk_unknown_cmd: assert property (wr_rise && dcx_l && param_pend && // [RULE10]
      cmd != bgt_pkg::CMD_UI_WHITE_RATIO && cmd != bgt_pkg::CMD_MOTION_STILL_FLOOR &&
      cmd != bgt_pkg::CMD_UI_GRAY_FLOOR |=>
      $stable(ui_white_ratio) && $stable(motion_still_gray_floor) && $stable(ui_gray_floor))
      else $error("unknown command changed a register");

   // one parameter byte pairs with one command byte
   chk_cmd_pending: assert property (wr_rise && !dcx_l |=> param_pend) // [RULE10]
      else $error("command did not arm its parameter");
   chk_param_closes: assert property (wr_rise && dcx_l && param_pend |=> !param_pend) // [RULE10]
      else $error("parameter did not close the command");

   // stored fields and values after reset
   chk_upper_zero: assert property (ui_white_ratio[7:4] == 4'h0 && // [RULE1] [RULE7]
      ui_gray_floor[7:4] == 4'h0)
      else $error("upper nibble of a ui setting not zero");
   chk_ratio_code: assert property (ui_white_ratio_code == ui_white_ratio[3:0]) // [RULE2]
      else $error("ratio code differs from its register");
   chk_reset_values: assert property (disable iff (1'b0) // [RULE1] [RULE4] [RULE7]
      sys_rst |=> ui_white_ratio == bgt_pkg::RST_UI_WHITE_RATIO &&
      motion_still_gray_floor == bgt_pkg::RST_MOTION_STILL_FLOOR &&
      ui_gray_floor == bgt_pkg::RST_UI_GRAY_FLOOR &&
      cmd == bgt_pkg::RST_CMD && !param_pend &&
      white_gray_threshold == bgt_pkg::RST_THRESHOLD &&
      pixel_out == bgt_pkg::RST_PIXEL_OUT)
      else $error("register not at its reset value");

   // a computed threshold under every floor lands exactly on the floor
   chk_moving_exact: assert property (content_mode == bgt_pkg::BGT_MODE_MOVING && // [RULE5]
      computed_gray_threshold < 8'd164 |=>
      white_gray_threshold == 8'(8'd224 - 8'd4 * $past(motion_code)))
      else $error("moving threshold not at floor");
   chk_still_exact: assert property (content_mode == bgt_pkg::BGT_MODE_STILL && // [RULE6]
      computed_gray_threshold < 8'd164 |=>
      white_gray_threshold == 8'(8'd224 - 8'd4 * $past(still_code)))
      else $error("still threshold not at floor");
   chk_ui_exact: assert property (content_mode == bgt_pkg::BGT_MODE_UI && // [RULE8]
      computed_gray_threshold < 8'd192 |=>
      white_gray_threshold == 8'(8'd252 - 8'd4 * $past(ui_code)))
      else $error("ui threshold not at floor");

   // flag and level follow the registered threshold
   chk_pixel_map: assert property (!sys_rst |=> // [RULE2]
      pixel_is_white == ($past(pixel_gray) >= $past(white_gray_threshold)) &&
      pixel_out == (pixel_is_white ? 6'd63 : $past(pixel_gray[7:2])))
      else $error("pixel flag or level wrong");
endmodule : bgt_threshold_regs

// *** bgt_pkg.sv ***
/*
 package for the backlight gray threshold register bank: command codes,
 reset values, floor tables and content modes.
 assumes nothing of its surroundings; every user writes bgt_pkg::name.
*/
package bgt_pkg;
   // command codes on the command bus
   localparam logic [7:0] CMD_UI_WHITE_RATIO       = 8'hCA;
   localparam logic [7:0] CMD_MOTION_STILL_FLOOR   = 8'hCB;
   localparam logic [7:0] CMD_UI_GRAY_FLOOR        = 8'hCC;
   // values after reset
   localparam logic [7:0] RST_UI_WHITE_RATIO       = 8'h0B;
   localparam logic [7:0] RST_MOTION_STILL_FLOOR   = 8'hA8;
   localparam logic [7:0] RST_UI_GRAY_FLOOR        = 8'h03;
   localparam logic [7:0] RST_CMD                  = 8'h00;
   localparam logic [7:0] RST_THRESHOLD            = 8'hFF;
   localparam logic [5:0] RST_PIXEL_OUT            = 6'h00;
   // field positions inside the parameter byte
   localparam int         CODE_W                   = 4;
   localparam int         MOTION_CODE_LSB          = 4;
   localparam int         STILL_CODE_LSB           = 0;
   // floor tables: base minus step times code
   localparam logic [7:0] MOTION_FLOOR_BASE        = 8'hE0;
   localparam logic [7:0] UI_FLOOR_BASE            = 8'hFC;
   localparam logic [7:0] FLOOR_STEP               = 8'h04;
   // full white output level
   localparam logic [5:0] WHITE_LEVEL              = 6'h3F;
   // pin bundle width and idle levels {dcx, rd_n, wr_n, data}
   localparam int         DATA_W                   = 24;
   localparam int         PIN_W                    = DATA_W + 3;
   localparam logic [26:0] PIN_IDLE                = 27'h700_0000;

   typedef enum logic [1:0] {
      BGT_MODE_MOVING,
      BGT_MODE_STILL,
      BGT_MODE_UI
   } bgt_mode_t;
endpackage : bgt_pkg

// *** bgt_pin_sync.sv ***
/*
 three-stage synchroniser for the command bus pins; a change is passed on
 once the second and third stages agree.
 assumes asynchronous pins and one system clock.
*/
`timescale 1ns/1ps
module bgt_pin_sync #(
   parameter int                W       = 1,
   parameter logic [W-1:0]      RST_VAL = '0
) (
   input  wire logic            clk,
   input  wire logic            sys_rst,
   input  wire logic [W-1:0]    pin_in,
   output logic      [W-1:0]    level
);
   logic [W-1:0] s1, s2, s3;
   logic [W-1:0] next_s1, next_s2, next_s3, next_level;

   // per-bit filter: second and third stage must agree
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_comb begin
            next_level[g] = (s2[g] == s3[g]) ? s3[g] : level[g];
         end
      end
   endgenerate

   // shift chain, first stage read only by the second
   always_comb begin
      next_s1 = pin_in;
      next_s2 = s1;
      next_s3 = s2;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1    <= RST_VAL;
         s2    <= RST_VAL;
         s3    <= RST_VAL;
         level <= RST_VAL;
      end else begin
         s1    <= next_s1;
         s2    <= next_s2;
         s3    <= next_s3;
         level <= next_level;
      end
   end
endmodule : bgt_pin_sync

// *** bgt_host.sv ***
/*
 host model for the command bus: a command byte, then its parameter byte.
 assumes the system clock paces the strobes; dcx, rd_n and wr_n idle high.
*/
`timescale 1ns/1ps
module bgt_host (
   input  wire logic        clk,
   output logic             dcx,
   output logic             rd_n,
   output logic             wr_n,
   output logic [23:0]      data
);
   // bus idle at time zero
   initial begin
      dcx = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      data = 24'h00_0000;
   end
   // strobe low four clocks, high four, then the data lines scrambled
   task automatic byte_out(input logic sel, input logic rd, input logic [7:0] b);
      @(posedge clk);
      #1 dcx = sel;
      rd_n = rd;
      data = {16'hA5C3, b}; // upper lines carry junk
      wr_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 wr_n = 1'b1; // byte taken on this rise
      repeat (4) @(posedge clk);
      #1 data = ~data;
      dcx = 1'b1;
      rd_n = 1'b1;
   endtask : byte_out
   // command with select low, then its parameter with select high
   task automatic send(input logic [7:0] cmd, input logic [7:0] par, input logic rd);
      byte_out(1'b0, rd, cmd);
      byte_out(1'b1, rd, par);
   endtask : send
endmodule : bgt_host

// *** backlight_gray_threshold_regs_bench.sv ***
/*
 bench for the gray threshold bank: table of writes and clamps, then pixel below
 threshold, refused writes and a second reset. assumes bgt_host.
*/
`timescale 1ns/1ps
module backlight_gray_threshold_regs_bench;
   typedef struct packed {
      logic [7:0]         cmd;
      logic [7:0]         par;
      bgt_pkg::bgt_mode_t md;
      logic [7:0]         cp;
      logic [31:0]        exp;
   } bgt_row_t;
   logic               clk, sys_rst, dcx, rd_n, wr_n, is_white;
   logic [23:0]        data;
   bgt_pkg::bgt_mode_t mode;
   logic [7:0]         comp, pix, ratio, msf, uif, thr;
   logic [3:0]         rcode;
   logic [5:0]         pout;
   int                 n_fail, n_compared, cycles;
   // expected {ratio, moving/still, ui floor, threshold} after each write
   bgt_row_t rows [7] = '{
      '{8'hCA, 8'hFF, bgt_pkg::BGT_MODE_UI, 8'h10, 32'h0FA8_03F0},
      '{8'hCB, 8'h0F, bgt_pkg::BGT_MODE_MOVING, 8'h10, 32'h0F0F_03E0},
      '{8'hCB, 8'hF0, bgt_pkg::BGT_MODE_MOVING, 8'h00, 32'h0FF0_03A4},
      '{8'hCC, 8'h0F, bgt_pkg::BGT_MODE_UI, 8'h00, 32'h0FF0_0FC0},
      '{8'hCC, 8'hF0, bgt_pkg::BGT_MODE_UI, 8'hFE, 32'h0FF0_00FE},
      '{8'hCB, 8'h3A, bgt_pkg::BGT_MODE_STILL, 8'h00, 32'h0F3A_00B8},
      '{8'hCA, 8'h00, bgt_pkg::BGT_MODE_UI, 8'h00, 32'h003A_00FC}};
   bgt_host host_u (.clk(clk), .dcx(dcx), .rd_n(rd_n), .wr_n(wr_n), .data(data));
   bgt_threshold_regs dut_u (
      .clk                     (clk),
      .sys_rst                 (sys_rst),
      .data_command_select     (dcx),
      .read_strobe_n           (rd_n),
      .write_strobe_n          (wr_n),
      .data_bus                (data),
      .content_mode            (mode),
      .computed_gray_threshold (comp),
      .pixel_gray              (pix),
      .ui_white_ratio          (ratio),
      .motion_still_gray_floor (msf),
      .ui_gray_floor           (uif),
      .ui_white_ratio_code     (rcode),
      .white_gray_threshold    (thr),
      .pixel_is_white          (is_white),
      .pixel_out               (pout));
   // 50 MHz clock
   always #10 clk = ~clk;
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic chk_regs(input logic [23:0] e);
      check("ratio", ratio, e[23:16]);
      check("ratio code", {4'h0, rcode}, {4'h0, e[19:16]});
      check("moving still", msf, e[15:8]);
      check("ui floor", uif, e[7:0]);
   endtask : chk_regs
   task automatic do_reset();
      @(posedge clk);
      #1 sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 check("reset threshold", thr, 8'hFF);
      check("reset level", {2'b00, pout}, 8'h00);
      check("reset flag", {7'h00, is_white}, 8'h00);
      sys_rst = 1'b0;
      @(posedge clk);
      #1 chk_regs(24'h0BA8_03);
   endtask : do_reset
   task automatic end_sim();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         end_sim();
      end
   end
   // table, then pixel below threshold, refusals and a second reset
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      mode = bgt_pkg::BGT_MODE_UI;
      comp = 8'h00;
      pix = 8'h00;
      n_fail = 0;
      n_compared = 0;
      cycles = 0;
      do_reset();
      foreach (rows[i]) begin
         host_u.send(rows[i].cmd, rows[i].par, 1'b1);
         repeat (3) @(posedge clk);
         #1 mode = rows[i].md;
         comp = rows[i].cp;
         pix = rows[i].exp[7:0];
         repeat (2) @(posedge clk);
         #1 chk_regs(rows[i].exp[31:8]);
         check("threshold", thr, rows[i].exp[7:0]);
         check("white out", {2'b00, pout}, 8'h3F);
         check("white flag", {7'h00, is_white}, 8'h01);
      end
      pix = 8'hFB;
      repeat (2) @(posedge clk);
      #1 check("dark out", {2'b00, pout}, 8'h3E);
      check("dark flag", {7'h00, is_white}, 8'h00);
      host_u.byte_out(1'b1, 1'b1, 8'h55);
      host_u.send(8'hC9, 8'h55, 1'b1);
      host_u.send(8'hCA, 8'h55, 1'b0);
      repeat (8) @(posedge clk);
      #1 chk_regs(24'h003A_00);
      do_reset();
      end_sim();
   end
endmodule : backlight_gray_threshold_regs_bench
